/* design/adcs_pkg.sv */
// shared constants, types and decode functions for the converter control
package adcs_pkg;
    // special function register addresses
    localparam logic [7:0] ADDR_CTRL = 8'hA1;
    localparam logic [7:0] ADDR_HIGH = 8'hA2;
    localparam logic [7:0] ADDR_LOW = 8'hA3;
    localparam logic [7:0] ADDR_STATIC = 8'hA4;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] STATIC_RESET = 8'h0A;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // converter_control fields
    localparam int CTRL_START_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_PWR_BIT = 5;
    localparam int CTRL_REF_BIT = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 0;
    localparam logic [3:0] SEL_SUPPLY = 4'h8;
    // static_config fields
    localparam int ST_DIFF_BIT = 7;
    localparam int ST_SLEEP_BIT = 6;
    localparam int ST_FAST_BIT = 5;
    localparam int ST_BIAS_MSB = 4;
    localparam int ST_BIAS_LSB = 2;
    localparam int ST_RES_MSB = 1;
    localparam int ST_RES_LSB = 0;
    // result_low flag positions
    localparam int LOW_UF_BIT = 2;
    localparam int LOW_OF_BIT = 1;
    localparam int LOW_RNG_BIT = 0;
    // timing: converter clock dividers and cycles beyond N/2
    localparam int DIV_SLOW = 32;
    localparam int DIV_FAST = 8;
    localparam logic [3:0] SINGLE_EXTRA = 4'h3;
    localparam logic [3:0] CONT_EXTRA = 4'h1;
    localparam int CODE_BITS = 12;
    localparam logic [3:0] RES_BASE_BITS = 4'h6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SINGLE = 2'b01,
        ST_CONT = 2'b10
    } adcs_state_t;

    // resolution code to number of result bits: 6, 8, 10, 12
    function automatic logic [3:0] res_bits(input logic [1:0] code);
        res_bits = RES_BASE_BITS + {1'b0, code, 1'b0};
    endfunction

    // converter clock cycles per conversion: N/2 plus a fixed extra
    function automatic logic [3:0] conv_len(input logic [1:0] code,
                                            input logic [3:0] extra);
        conv_len = (res_bits(code) >> 1) + extra;
    endfunction
endpackage

/* design/adcs_clock_div.sv */
// converter clock divider: cpu clock divided by 32 or by 8
`timescale 1ns/1ps
module adcs_clock_div #(
    parameter int SLOW_DIV = adcs_pkg::DIV_SLOW,
    parameter int FAST_DIV = adcs_pkg::DIV_FAST
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic fastSelect,
    output logic convTick,
    output logic convClk
);
    import adcs_pkg::*;

    // a five-bit counter serves dividers from 2 to 32
    if (SLOW_DIV > 32 || FAST_DIV < 2 || FAST_DIV > SLOW_DIV) begin : g_bad
        $error("adcs_clock_div: divider values out of range");
    end

    logic [4:0] divCnt;
    logic [4:0] lastCnt;
    logic [4:0] halfCnt;
    logic [4:0] next_divCnt;

    // end of period follows the select at once; a larger count wraps
    always_comb begin
        lastCnt = fastSelect ? 5'(FAST_DIV - 1) : 5'(SLOW_DIV - 1);
        halfCnt = fastSelect ? 5'(FAST_DIV / 2) : 5'(SLOW_DIV / 2);
        if (!enable || divCnt >= lastCnt) begin
            next_divCnt = 5'h00;
        end else begin
            next_divCnt = divCnt + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divCnt <= 5'h00;
        end else begin
            divCnt <= next_divCnt;
        end
    end

    // clock level rises together with the tick cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            convClk <= 1'b0;
        end else begin
            convClk <= enable && (next_divCnt < halfCnt); // RULE_03
        end
    end

    // tick marks the cycle that holds a rising converter clock edge
    assign convTick = enable && (divCnt == 5'h00); // RULE_03
endmodule

/* design/adcs_sequencer_control.sv */
// converter sequencing, control registers and result packing
//
// Functional notes
// [RULE_01] differential: selected input against input zero
// [RULE_02] static bit 6 selects reduced power
// [RULE_03] converter clock is cpu over 32 or 8
// [RULE_04] static bits 4-2 drive bias trim
// [RULE_05] resolution field picks 6, 8, 10, 12 bits
// [RULE_06] high register holds top eight bits
// [RULE_07] low nibble left justified, unused zero
// [RULE_08] underflow sets bit 2, data zero
// [RULE_09] overflow sets bit 1, data ones
// [RULE_10] bit 0 is underflow or overflow
// [RULE_11] every completion sets interrupt 2 flag
// [RULE_12] single conversion starts after toggle rises
// [RULE_13] one pulse when result reaches bus
// [RULE_14] single conversion lasts N/2 plus 3
// [RULE_15] software holds toggle low one clock
// [RULE_16] new toggle aborts running single conversion
// [RULE_17] continuous mode repeats every N/2 plus 1
// [RULE_18] above reference saturates at maximum code
// [RULE_19] code 8 measures supply, forces bandgap
// [RULE_20] reference bit picks pin or bandgap
// [RULE_21] differential zero gives mid scale code
// [RULE_22] control bit 6 continuous, bit 7 toggle
// [RULE_23] clearing control bit 5 powers down
// [RULE_24] input select field, control resets 0x80
// [RULE_25] results read only, updated together
`timescale 1ns/1ps
module adcs_sequencer_control #(
    parameter int SLOW_DIV = adcs_pkg::DIV_SLOW,
    parameter int FAST_DIV = adcs_pkg::DIV_FAST
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    output logic [7:0] sfrRdData,
    input wire logic [adcs_pkg::CODE_BITS-1:0] anaCode,
    input wire logic anaUnder,
    input wire logic anaOver,
    output logic anaPowerOn,
    output logic anaSleep,
    output logic anaDifferential,
    output logic [3:0] anaInputSel,
    output logic anaExtRef,
    output logic anaSupplyMeas,
    output logic [2:0] anaBiasTrim,
    output logic [1:0] anaResolution,
    output logic convClk,
    output logic anaSample,
    output logic eocPulse,
    output logic [adcs_pkg::CODE_BITS-1:0] resultBus
);
    import adcs_pkg::*;

    logic [7:0] ctrlReg;
    logic [7:0] staticReg;
    logic [7:0] resultHigh;
    logic [7:0] resultLow;
    adcs_state_t state;
    logic [3:0] tickCnt;
    logic startPrev;
    logic convTick;
    logic startBit;
    logic runBit;
    logic powerOn;
    logic [1:0] resSel;
    logic [3:0] singleLen;
    logic [3:0] contLen;
    logic startRise;
    logic sampleNow;
    logic complete;
    logic [3:0] nBits;
    logic [11:0] codeMask;
    logic [11:0] shaped;
    logic [7:0] next_high;
    logic [3:0] next_nibble;
    logic [2:0] next_flags;

    // field views of the control registers
    assign startBit = ctrlReg[CTRL_START_BIT]; // RULE_22
    assign runBit = ctrlReg[CTRL_RUN_BIT]; // RULE_22
    assign powerOn = ctrlReg[CTRL_PWR_BIT];
    assign resSel = staticReg[ST_RES_MSB:ST_RES_LSB];
    assign singleLen = conv_len(resSel, SINGLE_EXTRA);
    assign contLen = conv_len(resSel, CONT_EXTRA);

    // software writes reach control registers only; results are read only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlReg <= CTRL_RESET; // RULE_24
            staticReg <= STATIC_RESET;
        end else if (sfrWrite) begin
            if (sfrAddr == ADDR_CTRL) begin
                ctrlReg <= sfrWrData;
            end
            if (sfrAddr == ADDR_STATIC) begin
                staticReg <= sfrWrData;
            end
        end
    end

    // registered read port; unmapped addresses read as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfrRdData <= 8'h00;
        end else if (sfrRead) begin
            case (sfrAddr)
                ADDR_CTRL: sfrRdData <= ctrlReg;
                ADDR_HIGH: sfrRdData <= resultHigh;
                ADDR_LOW: sfrRdData <= resultLow;
                ADDR_STATIC: sfrRdData <= staticReg;
                default: sfrRdData <= 8'h00;
            endcase
        end
    end

    // analog controls are plain decodes of the register fields
    always_comb begin
        anaPowerOn = powerOn; // RULE_23
        anaSleep = staticReg[ST_SLEEP_BIT]; // RULE_02
        anaDifferential = staticReg[ST_DIFF_BIT]; // RULE_01
        anaInputSel = ctrlReg[SEL_MSB:SEL_LSB]; // RULE_24
        anaBiasTrim = staticReg[ST_BIAS_MSB:ST_BIAS_LSB]; // RULE_04
        anaResolution = resSel; // RULE_05
        anaSupplyMeas = (anaInputSel == SEL_SUPPLY); // RULE_19
        // supply measurement always uses the bandgap
        anaExtRef = ctrlReg[CTRL_REF_BIT] && !anaSupplyMeas; // RULE_20
    end

    // divider stops while powered down so nothing toggles
    adcs_clock_div #(
        .SLOW_DIV(SLOW_DIV),
        .FAST_DIV(FAST_DIV)
    ) u_div (
        .clk(clk),
        .nrst(nrst),
        .enable(powerOn), // RULE_23
        .fastSelect(staticReg[ST_FAST_BIT]), // RULE_03
        .convTick(convTick),
        .convClk(convClk)
    );

    // toggle is sampled only on converter clock edges
    assign startRise = convTick && !startPrev && startBit; // RULE_12

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            startPrev <= 1'b1;
        end else if (!powerOn) begin
            startPrev <= 1'b1;
        end else if (convTick) begin
            startPrev <= startBit; // RULE_22
        end
    end

    // a sample begins on start, on entering run, or each continuous wrap
    always_comb begin
        sampleNow = 1'b0;
        complete = 1'b0;
        if (powerOn && convTick) begin
            case (state)
                ST_IDLE: sampleNow = runBit || startRise; // RULE_12
                ST_SINGLE: begin
                    sampleNow = runBit;
                    complete = !runBit && startBit
                        && (tickCnt == singleLen); // RULE_14
                end
                ST_CONT: begin
                    complete = runBit && (tickCnt == contLen); // RULE_17
                    sampleNow = complete;
                end
                default: begin
                    sampleNow = 1'b0;
                    complete = 1'b0;
                end
            endcase
        end
    end

    // sequencing state; the toggle has no effect while running continuously
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            tickCnt <= 4'h0;
        end else if (!powerOn) begin
            state <= ST_IDLE; // RULE_23
            tickCnt <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (convTick && runBit) begin
                        state <= ST_CONT; // RULE_17
                        tickCnt <= 4'h1;
                    end else if (startRise) begin
                        state <= ST_SINGLE; // RULE_12
                        tickCnt <= 4'h1;
                    end
                end
                ST_SINGLE: begin
                    if (convTick && runBit) begin
                        state <= ST_CONT;
                        tickCnt <= 4'h1;
                    end else if (convTick && !startBit) begin
                        state <= ST_IDLE; // RULE_16
                        tickCnt <= 4'h0;
                    end else if (complete) begin
                        state <= ST_IDLE; // RULE_14
                        tickCnt <= 4'h0;
                    end else if (convTick) begin
                        tickCnt <= tickCnt + 4'h1;
                    end
                end
                ST_CONT: begin
                    if (!runBit) begin
                        state <= ST_IDLE;
                        tickCnt <= 4'h0;
                    end else if (complete) begin
                        tickCnt <= 4'h1; // RULE_17
                    end else if (convTick) begin
                        tickCnt <= tickCnt + 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    tickCnt <= 4'h0;
                end
            endcase
        end
    end

    // analog core sees one cpu-clock strobe per conversion start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            anaSample <= 1'b0;
        end else begin
            anaSample <= sampleNow;
        end
    end

    // shape the raw code: mid-scale offset, then clip, under clear to zero
    always_comb begin
        nBits = res_bits(resSel);
        codeMask = 12'hFFF >> (4'hC - nBits);
        shaped = anaCode & codeMask;
        if (anaDifferential) begin
            shaped = shaped ^ (12'h001 << (nBits - 4'h1)); // RULE_21
        end
        if (anaOver) begin
            shaped = codeMask; // RULE_09 RULE_18
        end else if (anaUnder) begin
            shaped = 12'h000; // RULE_08
        end
        next_flags = {anaUnder && !anaOver, anaOver,
            anaUnder || anaOver}; // RULE_10
        case (resSel)
            2'b00: begin
                next_high = {2'b00, shaped[5:0]}; // RULE_06
                next_nibble = 4'h0;
            end
            2'b01: begin
                next_high = shaped[7:0];
                next_nibble = 4'h0;
            end
            2'b10: begin
                next_high = shaped[9:2];
                next_nibble = {shaped[1:0], 2'b00}; // RULE_07
            end
            default: begin
                next_high = shaped[11:4];
                next_nibble = shaped[3:0]; // RULE_07
            end
        endcase
    end

    // data and flags land in one edge, with the end pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resultHigh <= RESULT_RESET;
            resultLow <= RESULT_RESET;
            resultBus <= 12'h000;
            eocPulse <= 1'b0;
        end else begin
            eocPulse <= complete; // RULE_11 RULE_13
            if (complete) begin
                resultHigh <= next_high; // RULE_25 RULE_05
                resultLow <= {next_nibble, 1'b0, next_flags}; // RULE_25
                resultBus <= shaped;
            end
        end
    end

    // ---- checks ----
    logic [7:0] tickAge;
    logic lastCont;
    logic [1:0] lastRes;
    logic [5:0] tickGap;
    logic gapSel;
    logic gapOk;

    // cpu cycles between converter ticks; a period is judged only when
    // power and the divider select stayed put over all of it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickGap <= 6'h00;
            gapSel <= 1'b0;
            gapOk <= 1'b0;
        end else if (convTick) begin
            tickGap <= 6'h01;
            gapSel <= staticReg[ST_FAST_BIT];
            gapOk <= 1'b1;
        end else begin
            tickGap <= tickGap + 6'h01;
            gapOk <= gapOk && powerOn
                && (staticReg[ST_FAST_BIT] == gapSel);
        end
    end

    // converter clock edges since the latest sample strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickAge <= 8'h00;
            lastCont <= 1'b0;
            lastRes <= 2'b00;
        end else if (anaSample) begin
            tickAge <= {7'h00, convTick};
            lastCont <= (state == ST_CONT);
            lastRes <= resSel;
        end else if (convTick) begin
            tickAge <= tickAge + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_eoc_single_pulse;
        eocPulse |=> !eocPulse;
    endproperty
    a_eoc_single_pulse: assert property (p_eoc_single_pulse) // RULE_13
        else $error("end pulse longer than one cycle");

    property p_single_len;
        eocPulse && !lastCont
            |-> tickAge == {4'h0, conv_len(lastRes, SINGLE_EXTRA)};
    endproperty
    a_single_len: assert property (p_single_len) // RULE_14
        else $error("single conversion length wrong");

    property p_cont_len;
        eocPulse && lastCont
            |-> tickAge == {4'h0, conv_len(lastRes, CONT_EXTRA)};
    endproperty
    a_cont_len: assert property (p_cont_len) // RULE_17
        else $error("continuous cycle time wrong");

    property p_fast_div;
        convTick && gapOk
            |-> tickGap == (gapSel ? 6'(FAST_DIV) : 6'(SLOW_DIV));
    endproperty
    a_fast_div: assert property (p_fast_div) // RULE_03
        else $error("converter clock period not cpu over 32 or 8");

    property p_underflow_zero;
        resultLow[LOW_UF_BIT] |-> resultHigh == 8'h00
            && resultLow[7:4] == 4'h0 && resultBus == 12'h000;
    endproperty
    a_underflow_zero: assert property (p_underflow_zero) // RULE_08
        else $error("underflow data not zero");

    property p_overflow_ones;
        eocPulse && resultLow[LOW_OF_BIT]
            |-> resultBus == (12'hFFF >> (4'hC - res_bits(lastRes)));
    endproperty
    a_overflow_ones: assert property (p_overflow_ones) // RULE_09
        else $error("overflow data not all ones");

    property p_range_or;
        resultLow[LOW_RNG_BIT]
            == (resultLow[LOW_UF_BIT] || resultLow[LOW_OF_BIT]);
    endproperty
    a_range_or: assert property (p_range_or) // RULE_10
        else $error("range flag not or of flags");

    property p_abort;
        state == ST_SINGLE && convTick && !startBit && !runBit
            && powerOn |=> state == ST_IDLE ##1 !eocPulse;
    endproperty
    a_abort: assert property (p_abort) // RULE_16
        else $error("single conversion not aborted");

    property p_power_down;
        !powerOn |-> !convTick ##1 (state == ST_IDLE && !eocPulse);
    endproperty
    a_power_down: assert property (p_power_down) // RULE_23
        else $error("converter active while powered down");

    property p_supply_ref;
        anaSupplyMeas |-> !anaExtRef;
    endproperty
    a_supply_ref: assert property (p_supply_ref) // RULE_19
        else $error("supply measurement not on bandgap");

    c_single_done: cover property (eocPulse && !lastCont);
    c_cont_done: cover property (eocPulse && lastCont);
    c_abort: cover property (state == ST_SINGLE && convTick && !startBit);
    c_overflow: cover property (eocPulse && resultLow[LOW_OF_BIT]);
endmodule

/* verification/adcs_analog_model.sv */
// behavioural analog core that answers each sample with a commanded code
`timescale 1ns/1ps
module adcs_analog_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic anaSample,
    input wire logic anaPowerOn,
    input wire logic [1:0] anaResolution,
    input wire logic [11:0] cmdCode,
    input wire logic cmdUnder,
    input wire logic cmdOver,
    output logic [11:0] anaCode,
    output logic anaUnder,
    output logic anaOver
);
    logic [11:0] held;
    logic [11:0] fullScale;

    // largest code at the chosen resolution
    assign fullScale = 12'hFFF >> (3'd6 - {anaResolution, 1'b0});

    // latch at the sample strobe; an input above the reference clips
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            held <= 12'h000;
        end else if (anaSample) begin
            held <= cmdOver ? fullScale : cmdCode;
        end
    end

    // a powered-down core holds nothing, so show the inverse of the last
    assign anaCode = anaPowerOn ? held : ~held;
    assign anaUnder = anaPowerOn & cmdUnder;
    assign anaOver = anaPowerOn & cmdOver;
endmodule

/* verification/adcs_sequencer_control_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcs_sequencer_control_tb;
    import adcs_pkg::*;
    // short dividers keep conversions to a few dozen cpu cycles
    localparam int SDIV = 4;
    localparam int FDIV = 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrRdData;
    logic [11:0] anaCode, resultBus, eocBus;
    logic [11:0] cmdCode = 12'h000;
    logic cmdUnder = 1'b0;
    logic cmdOver = 1'b0;
    logic anaUnder, anaOver, anaPowerOn, anaSleep, anaDifferential;
    logic anaExtRef, anaSupplyMeas, convClk, anaSample, eocPulse;
    logic [3:0] anaInputSel;
    logic [2:0] anaBiasTrim;
    logic [1:0] anaResolution;
    int failures = 0;
    int nTests = 0;
    int cyc = 0;
    int sampCyc = 0;
    int lastEoc = 0;
    int prevEoc = 0;
    int eocCount = 0;
    int clkRise = 0;
    logic clkPrev = 1'b0;

    adcs_sequencer_control #(.SLOW_DIV(SDIV), .FAST_DIV(FDIV)) uut (
        .clk, .nrst, .sfrAddr, .sfrWrData, .sfrWrite, .sfrRead,
        .sfrRdData, .anaCode, .anaUnder, .anaOver, .anaPowerOn,
        .anaSleep, .anaDifferential, .anaInputSel, .anaExtRef,
        .anaSupplyMeas, .anaBiasTrim, .anaResolution, .convClk,
        .anaSample, .eocPulse, .resultBus
    );

    adcs_analog_model model (
        .clk, .nrst, .anaSample, .anaPowerOn, .anaResolution, .cmdCode,
        .cmdUnder, .cmdOver, .anaCode, .anaUnder, .anaOver
    );

    initial begin
        forever #25 clk = ~clk;
    end

    // stamps of sample and completion pulses; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (convClk && !clkPrev) clkRise++;
        clkPrev = convClk;
        if (anaSample) sampCyc = cyc;
        if (eocPulse) begin
            prevEoc = lastEoc;
            lastEoc = cyc;
            eocBus = resultBus;
            eocCount++;
        end
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWrite <= 1'b1;
        @(posedge clk);
        sfrWrite <= 1'b0;
    endtask

    // read data is registered, so look a half cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                      input string what);
        @(posedge clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge clk);
        sfrRead <= 1'b0;
        @(negedge clk);
        chk(what, {4'h0, exp}, {4'h0, sfrRdData});
    endtask

    task automatic waitEoc(input int n);
        int i;
        for (i = 0; i < 600 && eocCount == n; i++)
            @(negedge clk);
        chk("eoc count", 12'h001, {11'h0, eocCount == n + 1});
    endtask

    // toggle held low for two slow ticks so it is always seen
    task automatic startSingle(input logic [4:0] refSel);
        wr(ADDR_CTRL, {3'b001, refSel});
        repeat (2 * SDIV) @(posedge clk);
        wr(ADDR_CTRL, {3'b101, refSel});
    endtask

    task automatic conv(input logic [1:0] res, input logic fast,
                        input logic diff, input logic [11:0] code,
                        input logic under, input logic over);
        int n, len, base;
        logic [11:0] d, sh;
        logic [7:0] hi, lo;
        n = 6 + 2 * res;
        len = n / 2 + 3;
        d = over ? 12'hFFF >> (12 - n) : under ? 12'h000 : code;
        if (diff && !over && !under) d[n-1] = ~d[n-1];
        sh = d << (12 - n);
        hi = res == 2'b00 ? {2'b00, d[5:0]} : sh[11:4];
        lo = {res == 2'b00 ? 4'h0 : sh[3:0], 1'b0, under & !over, over,
              under | over};
        wr(ADDR_STATIC, {diff, 1'b0, fast, 3'b010, res});
        cmdCode <= code;
        cmdUnder <= under;
        cmdOver <= over;
        base = eocCount;
        startSingle(5'h03);
        waitEoc(base);
        chk("length", 12'(len * (fast ? FDIV : SDIV)),
            12'(lastEoc - sampCyc));
        chk("bus at eoc", d, eocBus);
        rd(ADDR_HIGH, hi, "high");
        rd(ADDR_LOW, lo, "low");
    endtask

    // main sequence
    initial begin
        int base;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
        rd(ADDR_STATIC, STATIC_RESET, "static reset");
        rd(8'h55, 8'h00, "unmapped");
        chk("bias", 12'h002, {9'h0, anaBiasTrim});
        chk("res", 12'h002, {10'h0, anaResolution});
        chk("off", 12'h000, {11'h0, anaPowerOn | convClk});
        wr(ADDR_HIGH, 8'hFF);
        rd(ADDR_HIGH, 8'h00, "high read only");
        wr(ADDR_STATIC, 8'hC0);
        @(negedge clk);
        chk("sleep diff", 12'h003, {10'h0, anaSleep, anaDifferential});
        wr(ADDR_CTRL, 8'h98);
        @(negedge clk);
        chk("supply", 12'h001, {10'h0, anaExtRef, anaSupplyMeas});
        wr(ADDR_CTRL, 8'h93);
        @(negedge clk);
        chk("ext ref", 12'h023,
            {6'h0, anaExtRef, anaSupplyMeas, anaInputSel});
        // every resolution, alternating dividers, odd bit patterns
        for (int r = 0; r < 4; r++)
            conv(r[1:0], r[0], 1'b0, 12'hA5C >> (6 - 2 * r), 1'b0, 1'b0);
        conv(2'b10, 1'b1, 1'b0, 12'h155, 1'b1, 1'b0);
        conv(2'b11, 1'b0, 1'b0, 12'h123, 1'b0, 1'b1);
        conv(2'b01, 1'b1, 1'b0, 12'h00F, 1'b1, 1'b1);
        conv(2'b10, 1'b1, 1'b1, 12'h000, 1'b0, 1'b0);
        conv(2'b00, 1'b1, 1'b1, 12'h03F, 1'b0, 1'b0);
        // restart in mid conversion: one completion, timed from restart
        wr(ADDR_STATIC, 8'h2B);
        base = eocCount;
        startSingle(5'h01);
        repeat (6) @(posedge clk);
        startSingle(5'h01);
        waitEoc(base);
        chk("restart length", 12'd18, 12'(lastEoc - sampCyc));
        repeat (40) @(negedge clk);
        chk("single eoc", 12'(base + 1), 12'(eocCount));
        // continuous, toggle left low: 8 bit repeats every 5 ticks
        wr(ADDR_STATIC, 8'h29);
        wr(ADDR_CTRL, 8'h60);
        waitEoc(eocCount);
        base = clkRise;
        waitEoc(eocCount);
        chk("cycle time", 12'd10, 12'(lastEoc - prevEoc));
        chk("clock rises", 12'd5, 12'(clkRise - base));
        // power down in mid run stops everything
        wr(ADDR_CTRL, 8'h80);
        repeat (2) @(negedge clk);
        base = eocCount;
        repeat (60) @(negedge clk);
        chk("no eoc off", 12'(base), 12'(eocCount));
        chk("clock still", 12'h000, {11'h0, convClk});
        stop_test();
    end
endmodule
